// file: hw/ext_exec_pkg.sv
// Purpose: Shared constants and types for the extended skip, table-read and XOR executor
// Assumes: One instruction cycle per ref_clk; memories answer one cycle after a read strobe
// Notes: Reset values and the last program page are held here once
package ext_exec_pkg;
   localparam int DATA_W = 8;
   localparam int PM_DATA_W = 16;
   localparam int DM_ADDR_W = 8;
   localparam int PM_ADDR_W = 16;
   localparam int BIT_W = 3;
   localparam logic [7:0] LAST_PAGE = 8'hFF;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [7:0] PTR_INCR = 8'h01;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [7:0] PTR_LOW_RST = 8'h00;
   localparam logic [7:0] PTR_HIGH_RST = 8'h00;
   localparam logic [7:0] TABLE_HIGH_BYTE_REG_RST = 8'h00;
   localparam logic Z_RST = 1'b0;
   localparam int PM_LOW_LSB = 0;
   localparam int PM_HIGH_LSB = 8;
   // A taken skip spans three instruction cycles: its own plus two dummy ones
   localparam int SKIP_INSTR_CYCLES = 3;
   localparam int SKIP_DUMMY_CYCLES = SKIP_INSTR_CYCLES - 1;
   localparam logic [1:0] DUMMY_LAST = 2'(SKIP_DUMMY_CYCLES - 1);

   typedef enum logic [3:0] {
      OP_NONE                   = 4'h0,
      SKIP_IF_BYTE_ZERO         = 4'h1,
      MOVE_ACC_SKIP_IF_ZERO     = 4'h2,
      SKIP_IF_BIT_ZERO          = 4'h3,
      TABLE_READ_PAGE           = 4'h4,
      TABLE_READ_LAST_PAGE      = 4'h5,
      INCR_TABLE_READ_PAGE      = 4'h6,
      INCR_TABLE_READ_LAST_PAGE = 4'h7,
      XOR_TO_ACC                = 4'h8,
      XOR_TO_MEMORY             = 4'h9
   } op_t;

   typedef enum logic [6:0] {
      ST_IDLE    = 7'h01,
      ST_FETCH   = 7'h02,
      ST_CAPTURE = 7'h04,
      ST_PM_REQ  = 7'h08,
      ST_PM_CAP  = 7'h10,
      ST_WRITE   = 7'h20,
      ST_DUMMY   = 7'h40
   } state_t;
endpackage

// file: hw/table_addr_if.sv
// Purpose: Carries the table pointer and page select to the address former
// Assumes: Single clock domain, purely combinational signals
// Notes: None
`timescale 1ns/1ps
`default_nettype none
interface table_addr_if;
   logic [7:0] ptr_low;
   logic [7:0] ptr_high;
   logic last_sel;
   logic [15:0] addr;
   modport gen (input ptr_low, input ptr_high, input last_sel, output addr);
   modport user (output ptr_low, output ptr_high, output last_sel, input addr);
endinterface
`default_nettype wire

// file: hw/table_addr_gen.sv
// Purpose: Forms the program memory address of a table read
// Assumes: Last page is the top page of program memory
// Notes: Last-page reads ignore the high pointer entirely
`timescale 1ns/1ps
`default_nettype none
module table_addr_gen (
   table_addr_if.gen tif
);
   import ext_exec_pkg::*;
   wire logic [7:0] page_sel;
   assign page_sel = tif.last_sel ? LAST_PAGE : tif.ptr_high;
   assign tif.addr = {page_sel, tif.ptr_low};
endmodule
`default_nettype wire

// file: hw/ext_skip_table_xor_exec.sv
// Purpose: Executes byte and bit zero-skips, table reads and XOR operations
// Assumes: Data and program memory return read data one cycle after the strobe
// Notes: One state machine sequences every op; the address former sits in a submodule
`timescale 1ns/1ps
`default_nettype none
module ext_skip_table_xor_exec (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic op_valid,
   input wire ext_exec_pkg::op_t op_code,
   input wire logic [ext_exec_pkg::DM_ADDR_W-1:0] op_addr,
   input wire logic [ext_exec_pkg::BIT_W-1:0] op_bit,
   output logic op_ready,
   output logic op_done,
   output logic skip_taken,
   input wire logic acc_ld,
   input wire logic [7:0] acc_ld_data,
   input wire logic ptr_low_ld,
   input wire logic [7:0] ptr_low_ld_data,
   input wire logic ptr_high_ld,
   input wire logic [7:0] ptr_high_ld_data,
   output logic dm_rd_en,
   output logic dm_wr_en,
   output logic [ext_exec_pkg::DM_ADDR_W-1:0] dm_addr,
   output logic [7:0] dm_wdata,
   input wire logic [7:0] dm_rdata,
   output logic pm_rd_en,
   output logic [ext_exec_pkg::PM_ADDR_W-1:0] pm_addr,
   input wire logic [ext_exec_pkg::PM_DATA_W-1:0] pm_rdata,
   output logic [7:0] acc,
   output logic z_flag,
   output logic [7:0] table_ptr_low,
   output logic [7:0] table_ptr_high,
   output logic [7:0] table_high_byte_reg
);
   import ext_exec_pkg::*;

   state_t state_q, state_d;
   op_t op_q, op_d;
   logic [DM_ADDR_W-1:0] addr_q, addr_d;
   logic [BIT_W-1:0] bit_q, bit_d;
   logic [7:0] wdata_q, wdata_d;
   logic [7:0] acc_q, acc_d;
   logic z_q, z_d;
   logic [7:0] ptr_low_q, ptr_low_d;
   logic [7:0] ptr_high_q, ptr_high_d;
   logic [7:0] table_high_byte_reg_q, table_high_byte_reg_d;
   logic skip_q, skip_d;
   logic wr_q, wr_d;
   logic [1:0] dummy_q, dummy_d;

   table_addr_if tif ();

   table_addr_gen u_addr (
      .tif(tif)
   );

   wire logic st_idle;
   wire logic st_fetch;
   wire logic st_capture;
   wire logic st_pm_req;
   wire logic st_pm_cap;
   wire logic st_write;
   wire logic st_dummy;
   wire logic op_known;
   wire logic take;
   wire logic new_table;
   wire logic new_incr;
   wire logic last_op;
   wire logic byte_zero;
   wire logic rd_bit;
   wire logic [7:0] xor_res;
   wire logic xor_zero;
   wire logic dummy_end;

   assign st_idle = (state_q == ST_IDLE);
   assign st_fetch = (state_q == ST_FETCH);
   assign st_capture = (state_q == ST_CAPTURE);
   assign st_pm_req = (state_q == ST_PM_REQ);
   assign st_pm_cap = (state_q == ST_PM_CAP);
   assign st_write = (state_q == ST_WRITE);
   assign st_dummy = (state_q == ST_DUMMY);
   // Unknown codes are never taken, so the pipeline must not wait for a done on them
   assign op_known = (op_code != OP_NONE) && (op_code <= XOR_TO_MEMORY);
   assign take = st_idle && op_valid && op_known;
   assign new_table = (op_code >= TABLE_READ_PAGE) && (op_code <= INCR_TABLE_READ_LAST_PAGE);
   assign new_incr = (op_code == INCR_TABLE_READ_PAGE) || (op_code == INCR_TABLE_READ_LAST_PAGE);
   assign last_op = (op_q == TABLE_READ_LAST_PAGE) || (op_q == INCR_TABLE_READ_LAST_PAGE);
   assign byte_zero = (dm_rdata == ZERO_BYTE);
   assign rd_bit = dm_rdata[bit_q];
   assign xor_res = acc_q ^ dm_rdata;
   assign xor_zero = (xor_res == ZERO_BYTE);
   assign dummy_end = st_dummy && (dummy_q == DUMMY_LAST);

   assign tif.ptr_low = ptr_low_q;
   assign tif.ptr_high = ptr_high_q;
   assign tif.last_sel = last_op;

   assign op_ready = st_idle;
   assign op_done = (st_write && !skip_q) || dummy_end;
   assign skip_taken = st_write && skip_q;
   assign dm_rd_en = st_fetch;
   assign dm_wr_en = st_write && wr_q;
   assign dm_addr = addr_q;
   assign dm_wdata = wdata_q;
   assign pm_rd_en = st_pm_req;
   assign pm_addr = tif.addr;
   assign acc = acc_q;
   assign z_flag = z_q;
   assign table_ptr_low = ptr_low_q;
   assign table_ptr_high = ptr_high_q;
   assign table_high_byte_reg = table_high_byte_reg_q;

   always_comb begin
      state_d = state_q;
      op_d = op_q;
      addr_d = addr_q;
      bit_d = bit_q;
      wdata_d = wdata_q;
      acc_d = acc_q;
      z_d = z_q;
      ptr_low_d = ptr_low_q;
      ptr_high_d = ptr_high_q;
      table_high_byte_reg_d = table_high_byte_reg_q;
      skip_d = skip_q;
      wr_d = wr_q;
      dummy_d = dummy_q;
      case (state_q)
         ST_IDLE: begin
            if (take) begin
               op_d = op_code;
               addr_d = op_addr;
               bit_d = op_bit;
               skip_d = 1'b0;
               wr_d = 1'b0;
               state_d = new_table ? ST_PM_REQ : ST_FETCH;
               if (new_incr) begin
                  // Eight-bit wrap, the high pointer never sees a carry
                  ptr_low_d = ptr_low_q + PTR_INCR;
               end
            end else begin
               // Pipeline loads only land while idle, so a read never sees a torn pointer
               if (acc_ld) begin
                  acc_d = acc_ld_data;
               end
               if (ptr_low_ld) begin
                  ptr_low_d = ptr_low_ld_data;
               end
               if (ptr_high_ld) begin
                  ptr_high_d = ptr_high_ld_data;
               end
            end
         end
         ST_FETCH: begin
            state_d = ST_CAPTURE;
         end
         ST_CAPTURE: begin
            state_d = ST_WRITE;
            case (op_q)
               SKIP_IF_BYTE_ZERO: begin
                  wdata_d = dm_rdata;
                  wr_d = 1'b1;
                  skip_d = byte_zero;
               end
               MOVE_ACC_SKIP_IF_ZERO: begin
                  acc_d = dm_rdata;
                  skip_d = byte_zero;
               end
               SKIP_IF_BIT_ZERO: begin
                  skip_d = !rd_bit;
               end
               XOR_TO_ACC: begin
                  acc_d = xor_res;
                  z_d = xor_zero;
               end
               XOR_TO_MEMORY: begin
                  wdata_d = xor_res;
                  wr_d = 1'b1;
                  z_d = xor_zero;
               end
               default: begin
                  skip_d = 1'b0;
               end
            endcase
         end
         ST_PM_REQ: begin
            state_d = ST_PM_CAP;
         end
         ST_PM_CAP: begin
            wdata_d = pm_rdata[PM_LOW_LSB +: 8];
            table_high_byte_reg_d = pm_rdata[PM_HIGH_LSB +: 8];
            wr_d = 1'b1;
            state_d = ST_WRITE;
         end
         ST_WRITE: begin
            dummy_d = 2'h0;
            state_d = skip_q ? ST_DUMMY : ST_IDLE;
         end
         ST_DUMMY: begin
            if (dummy_q == DUMMY_LAST) begin
               state_d = ST_IDLE;
            end else begin
               dummy_d = dummy_q + 2'h1;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ST_IDLE;
         op_q <= OP_NONE;
         addr_q <= '0;
         bit_q <= '0;
         wdata_q <= ZERO_BYTE;
         acc_q <= ACC_RST;
         z_q <= Z_RST;
         ptr_low_q <= PTR_LOW_RST;
         ptr_high_q <= PTR_HIGH_RST;
         table_high_byte_reg_q <= TABLE_HIGH_BYTE_REG_RST;
         skip_q <= 1'b0;
         wr_q <= 1'b0;
         dummy_q <= 2'h0;
      end else begin
         state_q <= state_d;
         op_q <= op_d;
         addr_q <= addr_d;
         bit_q <= bit_d;
         wdata_q <= wdata_d;
         acc_q <= acc_d;
         z_q <= z_d;
         ptr_low_q <= ptr_low_d;
         ptr_high_q <= ptr_high_d;
         table_high_byte_reg_q <= table_high_byte_reg_d;
         skip_q <= skip_d;
         wr_q <= wr_d;
         dummy_q <= dummy_d;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   sequence dummy_run_s;
      st_dummy [*2] ##1 st_idle;
   endsequence

   sequence split_store_s;
      st_write && dm_wr_en && (dm_wdata == $past(pm_rdata[7:0]));
   endsequence

   byte_write_back_a: assert property (
      st_capture && op_q == SKIP_IF_BYTE_ZERO |=> st_write && dm_wr_en
         && dm_wdata == $past(dm_rdata) && skip_q == ($past(dm_rdata) == 8'h00))
      else $error("byte skip write-back or decision wrong");

   skip_dummy_len_a: assert property (
      st_write && skip_q |-> skip_taken && !op_done ##1 dummy_run_s)
      else $error("taken skip did not span two dummy cycles");

   skip_done_once_a: assert property (
      take ##1 st_fetch ##1 st_capture ##1 (st_write && skip_q) |-> ##2 op_done ##1 op_ready)
      else $error("skip completion not at expected cycle");

   move_acc_skip_a: assert property (
      st_capture && op_q == MOVE_ACC_SKIP_IF_ZERO |=> acc_q == $past(dm_rdata)
         && $stable(z_q) && !dm_wr_en && skip_q == (acc_q == 8'h00))
      else $error("move-and-skip result wrong");

   bit_skip_a: assert property (
      st_capture && op_q == SKIP_IF_BIT_ZERO |=> skip_q == !$past(rd_bit) && !dm_wr_en)
      else $error("bit skip decision wrong");

   page_addr_a: assert property (
      st_pm_req && !last_op |-> pm_addr == {ptr_high_q, ptr_low_q})
      else $error("page table address wrong");

   last_page_addr_a: assert property (
      st_pm_req && last_op |-> pm_addr == {8'hFF, ptr_low_q})
      else $error("last page table address wrong");

   table_split_a: assert property (
      st_pm_cap |=> (table_high_byte_reg_q == $past(pm_rdata[15:8])) and split_store_s)
      else $error("table word not split correctly");

   incr_first_a: assert property (
      take && new_incr |=> ptr_low_q == 8'($past(ptr_low_q) + 8'h01)
         && $stable(ptr_high_q) && st_pm_req)
      else $error("pointer not incremented before fetch");

   incr_last_addr_a: assert property (
      take && op_code == INCR_TABLE_READ_LAST_PAGE |=>
         pm_addr == {8'hFF, 8'($past(ptr_low_q) + 8'h01)})
      else $error("incremented last page address wrong");

   xor_acc_a: assert property (
      st_capture && op_q == XOR_TO_ACC |=> acc_q == ($past(acc_q) ^ $past(dm_rdata))
         && z_q == (acc_q == 8'h00) && !dm_wr_en)
      else $error("xor to accumulator wrong");

   xor_mem_a: assert property (
      st_capture && op_q == XOR_TO_MEMORY |=> $stable(acc_q) && dm_wr_en
         && dm_wdata == ($past(acc_q) ^ $past(dm_rdata)) && z_q == (dm_wdata == 8'h00))
      else $error("xor to memory wrong");

   flags_kept_a: assert property (
      !st_idle && op_q != XOR_TO_ACC && op_q != XOR_TO_MEMORY |=> $stable(z_q))
      else $error("flag changed by skip or table read");
endmodule
`default_nettype wire

// file: verif/exec_mem_model.sv
// Purpose: Data and program memory seen by the executor
// Assumes: Read data is due exactly one cycle after a strobe, no wait states
// Notes: Program words are a fixed pattern of the address, so no table is loaded
`timescale 1ns/1ps
`default_nettype none
module exec_mem_model (
   input wire logic ref_clk,
   input wire logic dm_rd_en,
   input wire logic dm_wr_en,
   input wire logic [7:0] dm_addr,
   input wire logic [7:0] dm_wdata,
   output var logic [7:0] dm_rdata,
   input wire logic pm_rd_en,
   input wire logic [15:0] pm_addr,
   output var logic [15:0] pm_rdata
);
   logic [7:0] mem [256];
   initial begin
      dm_rdata = 8'h00;
      pm_rdata = 16'h0000;
   end
   // Outside the answer cycle the buses toggle, so a late sample cannot match
   always @(posedge ref_clk) begin
      if (dm_wr_en) begin
         mem[dm_addr] <= dm_wdata;
      end
      dm_rdata <= dm_rd_en ? mem[dm_addr] : ~dm_rdata;
      pm_rdata <= pm_rd_en ? {pm_addr[7:0] ^ 8'h3C, pm_addr[15:8] ^ 8'hC3} : ~pm_rdata;
   end
endmodule
`default_nettype wire

// file: verif/test_ext_skip_table_xor_exec.sv
// Purpose: Self-checking bench for the skip, table-read and XOR executor
// Assumes: Ops are offered only while idle; memories answer in one cycle
// Notes: Cycle 1 is the first cycle after the take edge
`timescale 1ns/1ps
`default_nettype none
module test_ext_skip_table_xor_exec;
   import ext_exec_pkg::*;
   logic ref_clk = 1'b0, arst_n = 1'b0, op_valid = 1'b0;
   op_t op_code = OP_NONE;
   logic [7:0] op_addr = 8'h00;
   logic [2:0] op_bit = 3'h0;
   logic acc_ld = 1'b0, ptr_low_ld = 1'b0, ptr_high_ld = 1'b0;
   logic [7:0] acc_ld_data = 8'h00, ptr_low_ld_data = 8'h00, ptr_high_ld_data = 8'h00;
   logic op_ready, op_done, skip_taken, dm_rd_en, dm_wr_en, pm_rd_en, z_flag;
   logic [7:0] dm_addr, dm_wdata, dm_rdata, acc, table_ptr_low, table_ptr_high;
   logic [7:0] table_high_byte_reg;
   logic [15:0] pm_addr, pm_rdata, pm_a;
   logic wr_seen;
   logic [7:0] wr_val;
   int done_at, skip_at, mismatches = 0, checked = 0, cyc = 0;

   ext_skip_table_xor_exec u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .op_valid(op_valid),
      .op_code(op_code), .op_addr(op_addr), .op_bit(op_bit), .op_ready(op_ready),
      .op_done(op_done), .skip_taken(skip_taken), .acc_ld(acc_ld), .acc_ld_data(acc_ld_data),
      .ptr_low_ld(ptr_low_ld), .ptr_low_ld_data(ptr_low_ld_data), .ptr_high_ld(ptr_high_ld),
      .ptr_high_ld_data(ptr_high_ld_data), .dm_rd_en(dm_rd_en), .dm_wr_en(dm_wr_en),
      .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .pm_rd_en(pm_rd_en),
      .pm_addr(pm_addr), .pm_rdata(pm_rdata), .acc(acc), .z_flag(z_flag),
      .table_ptr_low(table_ptr_low), .table_ptr_high(table_ptr_high),
      .table_high_byte_reg(table_high_byte_reg));
   exec_mem_model u_mem (.ref_clk(ref_clk), .dm_rd_en(dm_rd_en), .dm_wr_en(dm_wr_en),
      .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .pm_rd_en(pm_rd_en),
      .pm_addr(pm_addr), .pm_rdata(pm_rdata));

   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Ceiling is generous: the whole sequence needs fewer than 150 cycles
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         mismatches++;
         give_verdict();
      end
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic load(input logic [7:0] av, input logic [7:0] lo, input logic [7:0] hi);
      @(posedge ref_clk);
      acc_ld <= 1'b1;
      ptr_low_ld <= 1'b1;
      ptr_high_ld <= 1'b1;
      acc_ld_data <= av;
      ptr_low_ld_data <= lo;
      ptr_high_ld_data <= hi;
      @(posedge ref_clk);
      acc_ld <= 1'b0;
      ptr_low_ld <= 1'b0;
      ptr_high_ld <= 1'b0;
   endtask

   // Offers one op, then watches every cycle up to and including op_done
   task automatic run_op(input op_t code, input logic [7:0] a, input logic [2:0] b);
      int n;
      wr_seen = 1'b0;
      skip_at = 0;
      done_at = 0;
      pm_a = 16'h0000;
      @(posedge ref_clk);
      op_valid <= 1'b1;
      op_code <= code;
      op_addr <= a;
      op_bit <= b;
      @(posedge ref_clk);
      op_valid <= 1'b0;
      op_code <= OP_NONE;
      #1;
      for (n = 1; n < 12; n++) begin
         if (skip_taken === 1'b1) skip_at = n;
         if (dm_wr_en === 1'b1) begin
            wr_seen = 1'b1;
            wr_val = dm_wdata;
         end
         if (pm_rd_en === 1'b1) pm_a = pm_addr;
         if (op_done === 1'b1) begin
            done_at = n;
            break;
         end
         @(posedge ref_clk);
         #1;
      end
      // One more edge so the closing memory write has landed before anyone looks
      @(posedge ref_clk);
      #1;
      chk("ready after op", 16'h0001, {15'h0000, op_ready});
   endtask

   // Codes outside the set are never taken, so the executor must stay idle
   task automatic t_refused();
      @(posedge ref_clk);
      op_valid <= 1'b1;
      op_code <= op_t'(4'hA);
      repeat (3) @(posedge ref_clk);
      #1;
      chk("bad code ignored", 16'h0001, {15'h0000, op_ready && !dm_rd_en && !pm_rd_en});
      @(posedge ref_clk);
      op_valid <= 1'b0;
      op_code <= OP_NONE;
   endtask

   task automatic chk_timing(input logic skip);
      chk("skip cycle", skip ? 16'd3 : 16'd0, 16'(skip_at));
      chk("done cycle", skip ? 16'd5 : 16'd3, 16'(done_at));
   endtask

   task automatic t_byte_skip();
      u_mem.mem[8'h10] = 8'h00;
      u_mem.mem[8'h11] = 8'h3C;
      run_op(SKIP_IF_BYTE_ZERO, 8'h10, 3'h0);
      chk_timing(1'b1);
      chk("byte skip write back", 16'h0100, {7'h00, wr_seen, wr_val});
      run_op(SKIP_IF_BYTE_ZERO, 8'h11, 3'h0);
      chk_timing(1'b0);
      chk("byte keep write back", 16'h013C, {7'h00, wr_seen, wr_val});
      chk("byte kept", 16'h003C, {8'h00, u_mem.mem[8'h11]});
   endtask

   task automatic t_move_skip();
      load(8'h55, 8'h00, 8'h00);
      u_mem.mem[8'h30] = 8'h00;
      u_mem.mem[8'h31] = 8'h81;
      run_op(MOVE_ACC_SKIP_IF_ZERO, 8'h30, 3'h0);
      chk_timing(1'b1);
      chk("move acc zero", 16'h0000, {8'h00, acc});
      run_op(MOVE_ACC_SKIP_IF_ZERO, 8'h31, 3'h0);
      chk_timing(1'b0);
      chk("move acc", 16'h0081, {8'h00, acc});
   endtask

   task automatic t_bit_skip();
      u_mem.mem[8'h40] = 8'hA5;
      for (int b = 0; b < 8; b++) begin
         run_op(SKIP_IF_BIT_ZERO, 8'h40, 3'(b));
         chk_timing(1'((8'h5A >> b) & 8'h01));
      end
   endtask

   task automatic tbl(input op_t code, input logic [7:0] m, input logic [15:0] a,
                      input logic [7:0] lo);
      run_op(code, m, 3'h0);
      chk("table done", 16'd3, 16'(done_at));
      chk("table address", a, pm_a);
      chk("table high byte", {8'h00, a[7:0] ^ 8'h3C}, {8'h00, table_high_byte_reg});
      chk("table low byte", {8'h00, a[15:8] ^ 8'hC3}, {8'h00, u_mem.mem[m]});
      chk("pointer", {8'h12, lo}, {table_ptr_high, table_ptr_low});
      chk("flag kept", 16'h0000, {15'h0000, z_flag});
   endtask

   task automatic t_table();
      load(8'h00, 8'hFF, 8'h12);
      tbl(TABLE_READ_PAGE, 8'h50, 16'h12FF, 8'hFF);
      tbl(TABLE_READ_LAST_PAGE, 8'h51, 16'hFFFF, 8'hFF);
      tbl(INCR_TABLE_READ_PAGE, 8'h52, 16'h1200, 8'h00);
      tbl(INCR_TABLE_READ_LAST_PAGE, 8'h53, 16'hFF01, 8'h01);
   endtask

   task automatic t_xor();
      load(8'hF0, 8'h00, 8'h00);
      u_mem.mem[8'h20] = 8'h0F;
      u_mem.mem[8'h21] = 8'hF0;
      run_op(XOR_TO_MEMORY, 8'h20, 3'h0);
      chk("xor memory", 16'h00FF, {8'h00, u_mem.mem[8'h20]});
      chk("xor memory acc z", 16'hF000, {acc, 7'h00, z_flag});
      run_op(XOR_TO_ACC, 8'h21, 3'h0);
      chk("xor acc z", 16'h0001, {acc, 7'h00, z_flag});
      chk("xor acc no write", 16'h0000, {15'h0000, wr_seen});
      run_op(SKIP_IF_BYTE_ZERO, 8'h20, 3'h0);
      chk("skip keeps z", 16'h0001, {15'h0000, z_flag});
      run_op(MOVE_ACC_SKIP_IF_ZERO, 8'h20, 3'h0);
      chk("move keeps z", 16'hFF01, {acc, 7'h00, z_flag});
   endtask

   initial begin
      repeat (10) @(posedge ref_clk);
      arst_n <= 1'b1;
      chk("reset state", 16'h0000, {acc, table_high_byte_reg});
      t_byte_skip();
      t_move_skip();
      t_bit_skip();
      t_table();
      t_xor();
      t_refused();
      give_verdict();
   end
endmodule
`default_nettype wire
